/* design/rmc_map.svh */
// constants of the radio mode controller: codes, state codes, timings
// assumes a 200 MHz core clock and an spi clock from the host
`ifndef RMC_MAP_SVH
`define RMC_MAP_SVH

`define RMC_CLK_NS 5
`define RMC_STARTUP_US 650
`define RMC_WAKE_US 75
`define RMC_LOCK_US 50

`define RMC_CMD_HEADER 8'h80

`define RMC_CODE_STANDBY 7'h40
`define RMC_CODE_SLEEP 7'h36
`define RMC_CODE_READY 7'h03
`define RMC_CODE_LOCK 7'h0f
`define RMC_CODE_RX 7'h33
`define RMC_CODE_TX 7'h5f
`define RMC_CODE_PROTO 7'h7f
`define RMC_CODE_NONE 7'h00

`endif

/* design/rmc_pkg.sv */
// types of the radio mode controller: states, command codes, carriers
// assumes rmc_map.svh is not needed here; codes live in the enums
`default_nettype none
package rmc_pkg;

   typedef enum logic [3:0] {
      RMC_ST_SHUTDOWN = 4'b0000,
      RMC_ST_STARTUP = 4'b0001,
      RMC_ST_READY = 4'b0010,
      RMC_ST_STANDBY = 4'b0011,
      RMC_ST_SLEEP = 4'b0100,
      RMC_ST_WAKE = 4'b0101,
      RMC_ST_LOCK = 4'b0110,
      RMC_ST_TX = 4'b0111,
      RMC_ST_RX = 4'b1000,
      RMC_ST_PROTO = 4'b1001
   } rmc_state_t;

   typedef enum logic [7:0] {
      RMC_CMD_TX = 8'h60,
      RMC_CMD_RX = 8'h61,
      RMC_CMD_READY = 8'h62,
      RMC_CMD_STANDBY = 8'h63,
      RMC_CMD_SLEEP = 8'h64,
      RMC_CMD_LOCK_RX = 8'h65,
      RMC_CMD_LOCK_TX = 8'h66,
      RMC_CMD_ABORT = 8'h67,
      RMC_CMD_WUT_RELOAD = 8'h68,
      RMC_CMD_SEQ_RELOAD = 8'h69,
      RMC_CMD_AES_ENC = 8'h6a,
      RMC_CMD_AES_KEY = 8'h6b,
      RMC_CMD_AES_DEC = 8'h6c,
      RMC_CMD_AES_KEYDEC = 8'h6d,
      RMC_CMD_SOFT_RESET = 8'h70,
      RMC_CMD_RX_FLUSH = 8'h71,
      RMC_CMD_TX_FLUSH = 8'h72
   } rmc_cmd_t;

   // completion events from engines on the core clock, one-cycle pulses
   typedef struct packed {
      logic tx_done;
      logic tx_underflow;
      logic rx_done;
      logic rx_timeout;
      logic rx_overflow;
      logic wakeup;
      logic proto_done;
      logic proto_to_tx;
      logic proto_to_rx;
   } rmc_evt_t;

   // configuration levels on the core clock
   typedef struct packed {
      logic direct_mode;
      logic persist_tx;
      logic persist_rx;
      logic protocol_on;
      logic low_duty_cycle_mode;
   } rmc_cfg_t;

   // one-cycle triggers to the engines outside
   typedef struct packed {
      logic wakeup_timer_reload;
      logic seq_reload;
      logic aes_enc;
      logic aes_key;
      logic aes_dec;
      logic aes_keydec;
      logic rx_queue_flush;
      logic tx_queue_flush;
   } rmc_trig_t;

endpackage : rmc_pkg
`default_nettype wire

/* design/rmc_ctrl.sv */
// radio mode controller: spi command decoder and main state machine
// assumes spi mode 0 (mosi sampled on rising spi_clk_i, msb first),
// engines and wakeup timer outside, analog lock detector on a pin
//
// How it works
// - shutdown pin high: state lost, spi and gpio drivers off
// - release from shutdown lands in READY, crystal running
// - startup 650 us; radio 125 us from standby/sleep, 50 us from ready
// - current state reported as the documented 7-bit code
// - standby keeps contents, timer off; sleep keeps timer running
// - receive and transmit are entered through LOCK, or directly from PROTO
// - direct turnaround only via protocol features; strobes abort first
// - READY, STANDBY, LOCK stable when entered by own command
// - READY or LOCK passed through on the way are transient
// - LOCK left for radio on lock detect or locking timeout, first wins
// - after lock commands hold LOCK and wait for next command
// - radio starts on command or on wake from sleep with pending job
// - transmit ends on packet sent, direct underflow, or abort
// - after transmit: persistent tx, protocol, else READY
// - receive ends on packet, timeout, direct overflow, or abort
// - after receive: persistent rx, protocol, sleep in ldc, else READY
// - abort always accepted in tx or rx, destination as completion
// - command acts when its sixteenth bit arrives, not at chip select
// - state commands honoured only in their listed states
// - reload, aes, soft reset and flush commands work in any state after startup
`include "rmc_map.svh"
`default_nettype none
module rmc_ctrl #(
   parameter int unsigned STARTUP_CYC = `RMC_STARTUP_US * 1000 / `RMC_CLK_NS,
   parameter int unsigned WAKE_CYC = `RMC_WAKE_US * 1000 / `RMC_CLK_NS,
   parameter int unsigned LOCK_CYC = `RMC_LOCK_US * 1000 / `RMC_CLK_NS,
   parameter int unsigned CNT_W = 18
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic shutdown_pin_i,
   input wire logic spi_clk_i,
   input wire logic spi_cs_b_i,
   input wire logic spi_mosi_i,
   input wire logic synth_lock_det_i,
   input wire rmc_pkg::rmc_evt_t evt_i,
   input wire rmc_pkg::rmc_cfg_t cfg_i,
   output logic [6:0] state_code_o,
   output logic port_drive_en_o,
   output logic crystal_osc_on_o,
   output logic synth_on_o,
   output logic synth_tx_cfg_o,
   output logic wakeup_timer_on_o,
   output logic tx_active_o,
   output logic rx_active_o,
   output rmc_pkg::rmc_trig_t trig_o
);
   import rmc_pkg::*;

   logic spi_rst_b;
   logic [14:0] spi_shift_reg;
   logic [3:0] spi_bit_cnt_reg;
   logic [7:0] spi_code_reg;
   logic spi_tgl_reg;
   logic [15:0] spi_word;

   // chip select high restarts byte framing; command latch survives it
   assign spi_rst_b = rst_b_i & ~spi_cs_b_i;
   assign spi_word = {spi_shift_reg, spi_mosi_i};

   always_ff @(posedge spi_clk_i or negedge spi_rst_b) begin
      if (!spi_rst_b) begin
         spi_shift_reg <= 15'h0000;
         spi_bit_cnt_reg <= 4'h0;
      end else begin
         spi_shift_reg <= spi_word[14:0];
         spi_bit_cnt_reg <= spi_bit_cnt_reg + 4'h1;
      end
   end

   // every full 16-bit pair is checked, so commands may be chained
   always_ff @(posedge spi_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         spi_code_reg <= 8'h00;
         spi_tgl_reg <= 1'b0;
      end else if (spi_cs_b_i == 1'b0 && spi_bit_cnt_reg == 4'hf &&
                   spi_word[15:8] == `RMC_CMD_HEADER) begin
         spi_code_reg <= spi_word[7:0];
         spi_tgl_reg <= ~spi_tgl_reg;
      end
   end

   logic [2:0] tgl_sync_reg;
   logic tgl_seen_reg;
   logic [2:0] sdn_sync_reg;
   logic sdn_level_reg;
   logic [2:0] lock_sync_reg;
   logic lock_level_reg;
   logic cmd_evt;
   rmc_cmd_t cmd;
   logic cmd_ok;

   // toggle crossing; code word is stable long before the toggle settles
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tgl_sync_reg <= 3'b000;
         tgl_seen_reg <= 1'b0;
      end else begin
         tgl_sync_reg <= {tgl_sync_reg[1:0], spi_tgl_reg};
         if (cmd_evt) begin
            tgl_seen_reg <= tgl_sync_reg[2];
         end
      end
   end

   assign cmd_evt = (tgl_sync_reg[1] == tgl_sync_reg[2]) &&
                    (tgl_sync_reg[2] != tgl_seen_reg);
   assign cmd = rmc_cmd_t'(spi_code_reg);

   // pins: three stages, level taken once stages two and three agree
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sdn_sync_reg <= 3'b111;
         sdn_level_reg <= 1'b1;
         lock_sync_reg <= 3'b000;
         lock_level_reg <= 1'b0;
      end else begin
         sdn_sync_reg <= {sdn_sync_reg[1:0], shutdown_pin_i};
         lock_sync_reg <= {lock_sync_reg[1:0], synth_lock_det_i};
         if (sdn_sync_reg[1] == sdn_sync_reg[2]) begin
            sdn_level_reg <= sdn_sync_reg[2];
         end
         if (lock_sync_reg[1] == lock_sync_reg[2]) begin
            lock_level_reg <= lock_sync_reg[2];
         end
      end
   end

   rmc_state_t state_reg;
   rmc_state_t state_next;
   logic [CNT_W-1:0] cnt_reg;
   logic dir_tx_reg;
   logic dir_tx_next;
   logic hold_reg;
   logic hold_next;
   logic pend_reg;
   logic pend_next;
   logic tx_end;
   logic rx_end;
   rmc_state_t tx_dest;
   rmc_state_t rx_dest;

   // commands are only honoured once powered up
   assign cmd_ok = cmd_evt && state_reg != RMC_ST_SHUTDOWN &&
                   state_reg != RMC_ST_STARTUP;

   assign tx_end = evt_i.tx_done ||
                   (cfg_i.direct_mode && evt_i.tx_underflow) ||
                   (cmd_ok && cmd == RMC_CMD_ABORT);
   assign rx_end = evt_i.rx_done || evt_i.rx_timeout ||
                   (cfg_i.direct_mode && evt_i.rx_overflow) ||
                   (cmd_ok && cmd == RMC_CMD_ABORT);

   always_comb begin
      if (cfg_i.persist_tx) begin
         tx_dest = RMC_ST_TX;
      end else if (cfg_i.protocol_on) begin
         tx_dest = RMC_ST_PROTO;
      end else begin
         tx_dest = RMC_ST_READY;
      end
      if (cfg_i.persist_rx) begin
         rx_dest = RMC_ST_RX;
      end else if (cfg_i.protocol_on) begin
         rx_dest = RMC_ST_PROTO;
      end else if (cfg_i.low_duty_cycle_mode) begin
         rx_dest = RMC_ST_SLEEP;
      end else begin
         rx_dest = RMC_ST_READY;
      end
   end

   always_comb begin
      state_next = state_reg;
      dir_tx_next = dir_tx_reg;
      hold_next = hold_reg;
      pend_next = pend_reg;
      case (state_reg)
         RMC_ST_SHUTDOWN: state_next = RMC_ST_STARTUP;
         RMC_ST_STARTUP: begin
            if (cnt_reg >= CNT_W'(STARTUP_CYC - 1)) begin
               state_next = RMC_ST_READY;
            end
         end
         RMC_ST_READY: begin
            // any command not listed here, except soft reset below, leaves the state alone
            if (cmd_ok) begin
               case (cmd)
                  RMC_CMD_TX, RMC_CMD_RX: begin
                     state_next = RMC_ST_LOCK;
                     dir_tx_next = (cmd == RMC_CMD_TX);
                     hold_next = 1'b0;
                  end
                  RMC_CMD_LOCK_RX, RMC_CMD_LOCK_TX: begin
                     state_next = RMC_ST_LOCK;
                     dir_tx_next = (cmd == RMC_CMD_LOCK_TX);
                     hold_next = 1'b1;
                  end
                  RMC_CMD_STANDBY: begin
                     state_next = RMC_ST_STANDBY;
                     pend_next = 1'b0;
                  end
                  RMC_CMD_SLEEP: begin
                     state_next = RMC_ST_SLEEP;
                     pend_next = 1'b0;
                  end
                  default: state_next = state_reg;
               endcase
            end
         end
         RMC_ST_STANDBY, RMC_ST_SLEEP: begin
            if (cmd_ok && cmd == RMC_CMD_READY) begin
               state_next = RMC_ST_WAKE;
               pend_next = 1'b0;
            end else if (state_reg == RMC_ST_SLEEP && evt_i.wakeup &&
                         pend_reg) begin
               state_next = RMC_ST_WAKE;
            end
         end
         RMC_ST_WAKE: begin
            // crystal restart; ready is transient when a job is pending
            if (cnt_reg >= CNT_W'(WAKE_CYC - 1)) begin
               if (pend_reg) begin
                  state_next = RMC_ST_LOCK;
                  hold_next = 1'b0;
               end else begin
                  state_next = RMC_ST_READY;
               end
            end
         end
         RMC_ST_LOCK: begin
            if (hold_reg) begin
               if (cmd_ok && cmd == RMC_CMD_READY) begin
                  state_next = RMC_ST_READY;
               end
            end else if (lock_level_reg ||
                         cnt_reg >= CNT_W'(LOCK_CYC - 1)) begin
               state_next = dir_tx_reg ? RMC_ST_TX : RMC_ST_RX;
               pend_next = 1'b0;
            end
         end
         RMC_ST_TX: begin
            if (tx_end) state_next = tx_dest;
         end
         RMC_ST_RX: begin
            if (rx_end) begin
               state_next = rx_dest;
               if (rx_dest == RMC_ST_SLEEP) begin
                  pend_next = 1'b1;
                  dir_tx_next = 1'b0;
               end
            end
         end
         RMC_ST_PROTO: begin
            if (evt_i.proto_to_tx) begin
               state_next = RMC_ST_TX;
            end else if (evt_i.proto_to_rx) begin
               state_next = RMC_ST_RX;
            end else if (evt_i.proto_done) begin
               state_next = RMC_ST_READY;
            end
         end
         default: state_next = RMC_ST_SHUTDOWN;
      endcase
      // soft reset re-runs the power-up pulse
      if (cmd_ok && cmd == RMC_CMD_SOFT_RESET) begin
         state_next = RMC_ST_STARTUP;
         dir_tx_next = 1'b0;
         hold_next = 1'b0;
         pend_next = 1'b0;
      end
      // shutdown overrides everything and drops all held state
      if (sdn_level_reg) begin
         state_next = RMC_ST_SHUTDOWN;
         dir_tx_next = 1'b0;
         hold_next = 1'b0;
         pend_next = 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg <= RMC_ST_SHUTDOWN;
         dir_tx_reg <= 1'b0;
         hold_reg <= 1'b0;
         pend_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         dir_tx_reg <= dir_tx_next;
         hold_reg <= hold_next;
         pend_reg <= pend_next;
      end
   end

   // one timer serves startup, wake and locking; restarts on every move
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_reg <= '0;
      end else if (state_next != state_reg) begin
         cnt_reg <= '0;
      end else if (cnt_reg != '1) begin
         cnt_reg <= cnt_reg + CNT_W'(1);
      end
   end

   // any-state triggers; registered so they are clean one-cycle pulses
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         trig_o <= '0;
      end else begin
         trig_o.wakeup_timer_reload <= cmd_ok &&
                                       cmd == RMC_CMD_WUT_RELOAD;
         trig_o.seq_reload <= cmd_ok && cmd == RMC_CMD_SEQ_RELOAD;
         trig_o.aes_enc <= cmd_ok && cmd == RMC_CMD_AES_ENC;
         trig_o.aes_key <= cmd_ok && cmd == RMC_CMD_AES_KEY;
         trig_o.aes_dec <= cmd_ok && cmd == RMC_CMD_AES_DEC;
         trig_o.aes_keydec <= cmd_ok && cmd == RMC_CMD_AES_KEYDEC;
         trig_o.rx_queue_flush <= cmd_ok && cmd == RMC_CMD_RX_FLUSH;
         trig_o.tx_queue_flush <= cmd_ok && cmd == RMC_CMD_TX_FLUSH;
      end
   end

   // status outputs follow the state register one cycle later
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_code_o <= `RMC_CODE_NONE;
         port_drive_en_o <= 1'b0;
         crystal_osc_on_o <= 1'b0;
         synth_on_o <= 1'b0;
         wakeup_timer_on_o <= 1'b0;
         tx_active_o <= 1'b0;
         rx_active_o <= 1'b0;
         synth_tx_cfg_o <= 1'b0;
      end else begin
         case (state_reg)
            RMC_ST_STANDBY: state_code_o <= `RMC_CODE_STANDBY;
            RMC_ST_SLEEP: state_code_o <= `RMC_CODE_SLEEP;
            RMC_ST_READY, RMC_ST_WAKE: state_code_o <= `RMC_CODE_READY;
            RMC_ST_LOCK: state_code_o <= `RMC_CODE_LOCK;
            RMC_ST_RX: state_code_o <= `RMC_CODE_RX;
            RMC_ST_TX: state_code_o <= `RMC_CODE_TX;
            RMC_ST_PROTO: state_code_o <= `RMC_CODE_PROTO;
            default: state_code_o <= `RMC_CODE_NONE;
         endcase
         port_drive_en_o <= state_reg != RMC_ST_SHUTDOWN;
         crystal_osc_on_o <= state_reg != RMC_ST_SHUTDOWN &&
                             state_reg != RMC_ST_STANDBY &&
                             state_reg != RMC_ST_SLEEP;
         synth_on_o <= state_reg == RMC_ST_LOCK ||
                       state_reg == RMC_ST_TX || state_reg == RMC_ST_RX;
         wakeup_timer_on_o <= state_reg == RMC_ST_SLEEP;
         tx_active_o <= state_reg == RMC_ST_TX;
         rx_active_o <= state_reg == RMC_ST_RX;
         synth_tx_cfg_o <= dir_tx_reg;
      end
   end

endmodule : rmc_ctrl
`default_nettype wire

/* bench/rmc_ctrl_chk.sv */
// port checker for the radio mode controller, core clock domain only
// assumes binding into rmc_ctrl with its count parameters handed on
`default_nettype none
module rmc_ctrl_chk #(
   parameter int unsigned STARTUP_CYC = 100,
   parameter int unsigned WAKE_CYC = 20,
   parameter int unsigned LOCK_CYC = 20
) (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic shutdown_pin_i,
   input wire logic spi_cs_b_i,
   input wire logic [6:0] state_code_o,
   input wire logic port_drive_en_o,
   input wire logic crystal_osc_on_o,
   input wire logic synth_on_o,
   input wire logic wakeup_timer_on_o,
   input wire logic tx_active_o,
   input wire logic rx_active_o,
   input wire rmc_pkg::rmc_trig_t trig_o
);
   timeunit 1ns;
   timeprecision 100ps;
   import rmc_pkg::*;
   int unsigned boot_cnt_reg;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   // startup length; slack covers the shutdown pin synchroniser
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         boot_cnt_reg <= 0;
      end else if (state_code_o == 7'h00 && !shutdown_pin_i) begin
         boot_cnt_reg <= boot_cnt_reg + 1;
      end else begin
         boot_cnt_reg <= 0;
      end
   end
   sequence s_off;
      shutdown_pin_i [*8];
   endsequence
   // no frame and no shutdown for longer than the command crossing
   sequence s_quiet;
      (spi_cs_b_i && !shutdown_pin_i) [*8];
   endsequence
   property p_off;
      s_off |-> state_code_o == 7'h00 && !port_drive_en_o;
   endproperty
   a_off: assert property (p_off)
      else $error("device live while shut down");
   property p_code;
      state_code_o inside {7'h40, 7'h36, 7'h03, 7'h0f, 7'h33, 7'h5f,
         7'h7f, 7'h00};
   endproperty
   a_code: assert property (p_code)
      else $error("state code outside the known set");
   property p_rest;
      state_code_o inside {7'h40, 7'h36} |-> !crystal_osc_on_o &&
         wakeup_timer_on_o == (state_code_o == 7'h36);
   endproperty
   a_rest: assert property (p_rest)
      else $error("standby or sleep power state wrong");
   property p_via_lock;
      $changed(state_code_o) && state_code_o inside {7'h33, 7'h5f} |->
         $past(state_code_o) inside {7'h0f, 7'h7f};
   endproperty
   a_via_lock: assert property (p_via_lock)
      else $error("radio entered without lock");
   property p_hold;
      s_quiet ##0 state_code_o == 7'h40 |=> state_code_o == 7'h40;
   endproperty
   a_hold: assert property (p_hold)
      else $error("standby left with no command");
   property p_synth;
      state_code_o inside {7'h0f, 7'h33, 7'h5f} |-> synth_on_o;
   endproperty
   a_synth: assert property (p_synth)
      else $error("synthesizer off in lock or radio state");
   property p_active;
      tx_active_o == (state_code_o == 7'h5f) &&
         rx_active_o == (state_code_o == 7'h33);
   endproperty
   a_active: assert property (p_active)
      else $error("radio activity disagrees with state code");
   property p_trig;
      |trig_o |-> $onehot0(trig_o) ##1 trig_o == '0;
   endproperty
   a_trig: assert property (p_trig)
      else $error("trigger not a single one-cycle pulse");
   property p_boot;
      boot_cnt_reg <= STARTUP_CYC + 10;
   endproperty
   a_boot: assert property (p_boot)
      else $error("startup too long");
endmodule : rmc_ctrl_chk
bind rmc_ctrl rmc_ctrl_chk #(.STARTUP_CYC(STARTUP_CYC),
   .WAKE_CYC(WAKE_CYC), .LOCK_CYC(LOCK_CYC)) u_chk (
   .clock_i(clock_i), .rst_b_i(rst_b_i),
   .shutdown_pin_i(shutdown_pin_i), .spi_cs_b_i(spi_cs_b_i),
   .state_code_o(state_code_o), .port_drive_en_o(port_drive_en_o),
   .crystal_osc_on_o(crystal_osc_on_o), .synth_on_o(synth_on_o),
   .wakeup_timer_on_o(wakeup_timer_on_o), .tx_active_o(tx_active_o),
   .rx_active_o(rx_active_o), .trig_o(trig_o));
`default_nettype wire

/* bench/rmc_host.sv */
// host model: spi master sending two-byte command frames
// assumes mode 0, msb first, clock stopped low outside frames
`default_nettype none
module rmc_host (
   output logic spi_clk_o,
   output logic spi_cs_b_o,
   output logic spi_mosi_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      spi_clk_o = 1'b0;
      spi_cs_b_o = 1'b1;
      spi_mosi_o = 1'b0;
   end
   // slow lengthens the idle gap before select; keep leaves select low
   task automatic send(input logic [7:0] hdr, input logic [7:0] code,
      input int slow, input logic keep);
      logic [15:0] bits;
      bits = {hdr, code};
      // gap keeps select from toggling twice in one step between frames
      #(24 + slow);
      spi_cs_b_o = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         spi_mosi_o = bits[i];
         #24;
         spi_clk_o = 1'b1;
         #24;
         spi_clk_o = 1'b0;
      end
      #24;
      spi_cs_b_o = keep ? 1'b0 : 1'b1;
      // released line: no stale last bit
      spi_mosi_o = ~bits[0];
   endtask : send
endmodule : rmc_host
`default_nettype wire

/* bench/rmc_ctrl_tb_top.sv */
// self-checking bench of the radio mode controller
// assumes rmc_host for spi frames and the bound port checker
`default_nettype none
module rmc_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import rmc_pkg::*;
   localparam int ST = 100;
   localparam int LK = 20;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic shutdown_pin = 1'b1;
   logic lock_det = 1'b0;
   logic sck, cs_b, mosi, drv, xo, syn, stx, wut, txa, rxa;
   logic [6:0] code;
   logic [6:0] cur = 7'h00;
   rmc_evt_t evt = '0;
   rmc_cfg_t cfg = '0;
   rmc_trig_t trig;
   logic [7:0] trig_seen = '0;
   int fails = 0;
   int checks_done = 0;
   int seed = 1606;
   int lock_run = 0;
   int lock_len = 0;
   rmc_ctrl #(.STARTUP_CYC(ST), .WAKE_CYC(20), .LOCK_CYC(LK)) dut (
      .clock_i(clk), .rst_b_i(rst_b), .shutdown_pin_i(shutdown_pin),
      .spi_clk_i(sck), .spi_cs_b_i(cs_b), .spi_mosi_i(mosi),
      .synth_lock_det_i(lock_det), .evt_i(evt), .cfg_i(cfg),
      .state_code_o(code), .port_drive_en_o(drv), .crystal_osc_on_o(xo),
      .synth_on_o(syn), .synth_tx_cfg_o(stx), .wakeup_timer_on_o(wut),
      .tx_active_o(txa), .rx_active_o(rxa), .trig_o(trig));
   rmc_host host (.spi_clk_o(sck), .spi_cs_b_o(cs_b), .spi_mosi_o(mosi));
   always #2.5 clk = ~clk;
   always @(posedge clk) trig_seen <= trig_seen | trig;
   // length of the last stay in lock
   always @(posedge clk) begin
      if (code === 7'h0f) begin
         lock_run <= lock_run + 1;
      end else if (lock_run != 0) begin
         lock_len <= lock_run;
         lock_run <= 0;
      end
   end
   // expected state after a command; wrong-state commands change nothing
   function automatic logic [6:0] model(input logic [6:0] s,
      input logic [7:0] c);
      model = s;
      case (c)
         8'h60: if (s == 7'h03) model = 7'h5f;
         8'h61: if (s == 7'h03) model = 7'h33;
         8'h62: if (s inside {7'h40, 7'h36, 7'h0f}) model = 7'h03;
         8'h63: if (s == 7'h03) model = 7'h40;
         8'h64: if (s == 7'h03) model = 7'h36;
         8'h65, 8'h66: if (s == 7'h03) model = 7'h0f;
         8'h67: if (s inside {7'h5f, 7'h33}) model = 7'h03;
         default: ;
      endcase
   endfunction : model
   task automatic check(input string what, input logic [7:0] got,
      input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic await(input logic [6:0] e, input int n, output int k);
      for (k = 0; k < n && code !== e; k++) begin
         @(negedge clk);
      end
   endtask : await
   // wait for a state, then let late changes show before comparing
   task automatic settle(input logic [6:0] e, input int n);
      int k;
      await(e, n, k);
      repeat (8) @(negedge clk);
      check("state", {1'b0, code}, {1'b0, e});
      cur = e;
   endtask : settle
   task automatic cmd(input logic [7:0] c, input int n);
      host.send(8'h80, c, $unsigned($random(seed)) % 40, 1'b0);
      settle(model(cur, c), n);
   endtask : cmd
   task automatic ev(input int b);
      evt[b] = 1'b1;
      @(negedge clk);
      evt = '0;
   endtask : ev
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results
   initial begin
      #400_000;
      fails++;
      results();
   end
   initial begin
      int k;
      logic [7:0] c;
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      repeat (6) @(negedge clk);
      check("drive", {7'h00, drv}, 8'h00);
      shutdown_pin = 1'b0;
      await(7'h03, ST + 40, k);
      check("boot", {7'h00, k >= ST}, 8'h01);
      settle(7'h03, 1);
      check("xo", {7'h00, xo}, 8'h01);
      repeat (3) begin
         host.send(8'h81, 8'h63, 0, 1'b0);
         cmd(8'($unsigned($random(seed)) % 96), 8);
      end
      cmd(8'h62, 8);
      cmd(8'h67, 8);
      cmd(8'h63, 40);
      check("xo", {7'h00, xo}, 8'h00);
      cmd(8'h60, 8);
      cmd(8'h62, 60);
      cmd(8'h64, 40);
      check("wut", {7'h00, wut}, 8'h01);
      cmd(8'h62, 60);
      cmd(8'h65, 60);
      repeat (2 * LK) @(negedge clk);
      check("held", {stx, code}, 8'h0f);
      cmd(8'h62, 40);
      host.send(8'h80, 8'h66, 0, 1'b1);
      settle(7'h0f, 60);
      check("txcfg", {7'h00, stx}, 8'h01);
      cmd(8'h62, 40);
      lock_det = 1'b1;
      cmd(8'h60, 80);
      check("fast", {7'h00, lock_len < LK}, 8'h01);
      repeat (30) @(negedge clk);
      check("txhold", {1'b0, code}, 8'h5f);
      ev(8);
      settle(7'h03, 20);
      cfg.persist_tx = 1'b1;
      cmd(8'h60, 80);
      ev(8);
      settle(7'h5f, 1);
      cfg.persist_tx = 1'b0;
      cmd(8'h67, 20);
      cfg.protocol_on = 1'b1;
      cmd(8'h60, 80);
      ev(8);
      settle(7'h7f, 20);
      ev(0);
      settle(7'h33, 40);
      ev(6);
      settle(7'h7f, 20);
      ev(1);
      settle(7'h5f, 20);
      ev(8);
      settle(7'h7f, 20);
      ev(2);
      settle(7'h03, 20);
      cmd(8'h61, 80);
      cfg.protocol_on = 1'b0;
      ev(6);
      settle(7'h03, 20);
      cfg.direct_mode = 1'b1;
      cmd(8'h60, 80);
      ev(7);
      settle(7'h03, 20);
      cmd(8'h61, 80);
      ev(4);
      settle(7'h03, 20);
      cfg.direct_mode = 1'b0;
      lock_det = 1'b0;
      cmd(8'h61, 80);
      check("slow", {7'h00, lock_len >= LK}, 8'h01);
      ev(4);
      settle(7'h33, 1);
      cfg.persist_rx = 1'b1;
      ev(6);
      settle(7'h33, 1);
      cfg.persist_rx = 1'b0;
      cfg.low_duty_cycle_mode = 1'b1;
      ev(5);
      settle(7'h36, 20);
      ev(3);
      settle(7'h33, 200);
      cfg.low_duty_cycle_mode = 1'b0;
      cmd(8'h67, 20);
      cmd(8'h63, 40);
      for (int i = 0; i < 8; i++) begin
         c = (i < 6) ? 8'h68 + 8'(i) : 8'h6b + 8'(i);
         trig_seen = '0;
         cmd(c, 8);
         check("trig", trig_seen, 8'h80 >> i);
      end
      host.send(8'h80, 8'h70, 0, 1'b0);
      await(7'h00, 20, k);
      check("soft_reset_cmd", {1'b0, code}, 8'h00);
      await(7'h03, ST + 40, k);
      settle(7'h03, 1);
      lock_det = 1'b1;
      cmd(8'h60, 80);
      shutdown_pin = 1'b1;
      repeat (10) @(negedge clk);
      check("off", {drv, code}, 8'h00);
      shutdown_pin = 1'b0;
      await(7'h03, ST + 40, k);
      check("reboot", {7'h00, k >= ST}, 8'h01);
      results();
   end
endmodule : rmc_ctrl_tb_top
`default_nettype wire
